// ---- ssp_peer.sv ----
`timescale 1ns/10ps
module ssp_peer (
  // pin side
  input wire logic core_clk_i,
  input wire logic sclk_w_i,
  input wire logic sdo_w_i,
  input wire logic go_i,
  input wire logic [7:0] tx_i,
  output logic sclk_drv_o,
  output logic sdi_o,
  output logic [7:0] rx_o
);
  int cnt = 0;
  int hold = 0;
  logic infr = 1'b0;
  initial
  begin
    sclk_drv_o = 1'b1;
    sdi_o = 1'b0;
  end
  // next bit on each falling edge, msb first
  always @(negedge sclk_w_i)
  begin
    infr = 1'b1;
    sdi_o <= tx_i[7 - cnt];
  end
  // capture on rising edges, eighth ends frame
  always @(posedge sclk_w_i)
    if (infr)
    begin
      rx_o <= {rx_o[6:0], sdo_w_i};
      hold = 10;
      cnt = (cnt + 1) % 8;
      infr = (cnt != 0);
    end
  // data held, then changes every cycle
  always @(posedge core_clk_i)
    if (hold > 0)
      hold--;
    else if (!infr)
      sdi_o <= ~sdi_o;
  // eight slow pulses, resting high
  always @(posedge core_clk_i)
    if (go_i)
      repeat (8)
      begin
        sclk_drv_o <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        sclk_drv_o <= 1'b1;
        repeat (4) @(posedge core_clk_i);
      end
endmodule

// ---- ssp_pkg.sv ----
package ssp_pkg;
  // register offsets
  localparam logic [7:0] SSP_OFS_CONTROL = 8'h0A;
  localparam logic [7:0] SSP_OFS_STATUS = 8'h0B;
  localparam logic [7:0] SSP_OFS_DATA = 8'h0C;
  // control bit positions
  localparam int SSP_CTL_MASTER_BIT = 4;
  localparam int SSP_CTL_ENABLE_BIT = 6;
  // status bit positions
  localparam int SSP_STS_COLL_BIT = 6;
  localparam int SSP_STS_DONE_BIT = 7;
  // bits per transfer
  localparam logic [3:0] SSP_BITS = 4'h8;
  // rate select codes: osc divided by 2, 4, 8, 16
  localparam logic [1:0] SSP_DIV2 = 2'h0;
  localparam logic [1:0] SSP_DIV4 = 2'h1;
  localparam logic [1:0] SSP_DIV8 = 2'h2;
  localparam logic [1:0] SSP_DIV16 = 2'h3;
  // master engine states
  typedef enum logic [2:0] {
    SSP_IDLE = 3'b001,
    SSP_LOW = 3'b010,
    SSP_HIGH = 3'b100
  } ssp_state_t;
endpackage

// ---- ssp_top.sv ----
`timescale 1ns/10ps
module ssp_top
  import ssp_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // mask options
  input wire logic [1:0] rate_sel_i,
  input wire logic lsb_first_i,
  // general purpose port b bit five level
  input wire logic port_b_bit_five_i,
  // serial pins
  input wire logic serial_in_line_i,
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe_o,
  output logic serial_out_line_o,
  output logic serial_out_oe_o,
  output logic serial_in_used_o
);

  // divider terminal count for the selected rate (half period minus one)
  function automatic logic [2:0] half_count(input logic [1:0] sel);
    case (sel)
      SSP_DIV2: half_count = 3'h0;
      SSP_DIV4: half_count = 3'h1;
      SSP_DIV8: half_count = 3'h3;
      default: half_count = 3'h7;
    endcase
  endfunction

  // bit to transmit next, in the chosen order
  function automatic logic out_bit(input logic [7:0] d, input logic lsb);
    out_bit = lsb ? d[0] : d[7];
  endfunction

  logic enable_reg, enable_next;
  logic master_reg, master_next;
  logic done_reg, done_next;
  logic coll_reg, coll_next;
  logic armed_reg, armed_next;
  logic busy_reg, busy_next;
  logic [7:0] data_reg, data_next;
  logic [3:0] count_reg, count_next;
  logic [2:0] div_reg, div_next;
  logic sin_reg, sin_next;
  logic sclk_in_reg, sclk_in_next;
  ssp_state_t state_reg, state_next;
  logic [7:0] rdata_reg, rdata_next;
  logic sclk_reg, sclk_next;
  logic sclk_oe_reg, sclk_oe_next;
  logic sout_reg, sout_next;
  logic sout_oe_reg, sout_oe_next;
  logic sin_used_reg, sin_used_next;

  logic data_acc;
  logic fall_ev;
  logic rise_ev;
  logic sclk_now;
  logic halt;

  // register access decode
  always_comb
  begin
    data_acc = 1'b0;
    if ((wr_i || rd_i) && addr_i == SSP_OFS_DATA)
    begin
      data_acc = 1'b1;
    end
  end

  // serial clock edges: internal engine or external pin
  always_comb
  begin
    halt = !enable_reg || !master_reg;
    sclk_now = master_reg ? sclk_reg : sclk_i;
    fall_ev = 1'b0;
    rise_ev = 1'b0;
    if (enable_reg)
    begin
      // master acts on the edge it launches, so data leads the next rise
      fall_ev = master_reg ? (sclk_reg && !sclk_next) : (sclk_in_reg && !sclk_now);
      rise_ev = !sclk_in_reg && sclk_now;
    end
  end

  // master clock generator
  always_comb
  begin
    state_next = state_reg;
    div_next = div_reg;
    sclk_next = sclk_reg;
    if (halt)
    begin
      state_next = SSP_IDLE;
      div_next = 3'h0;
      sclk_next = 1'b1;
    end
    else
    begin
      case (state_reg)
        SSP_IDLE:
        begin
          div_next = 3'h0;
          sclk_next = 1'b1;
          if (wr_i && addr_i == SSP_OFS_DATA)
          begin
            state_next = SSP_LOW;
            sclk_next = 1'b0;
          end
        end
        SSP_LOW:
        begin
          div_next = div_reg + 3'h1;
          if (div_reg == half_count(rate_sel_i))
          begin
            div_next = 3'h0;
            sclk_next = 1'b1;
            state_next = SSP_HIGH;
          end
        end
        SSP_HIGH:
        begin
          div_next = div_reg + 3'h1;
          // stop on the eighth rise even when the high phase is one cycle
          if (count_reg == SSP_BITS || (rise_ev && count_reg == SSP_BITS - 4'h1))
          begin
            state_next = SSP_IDLE;
            div_next = 3'h0;
          end
          else if (div_reg == half_count(rate_sel_i))
          begin
            div_next = 3'h0;
            sclk_next = 1'b0;
            state_next = SSP_LOW;
          end
        end
        default:
        begin
          state_next = SSP_IDLE;
          sclk_next = 1'b1;
        end
      endcase
    end
  end

  // shifter, counter and flags
  always_comb
  begin
    enable_next = enable_reg;
    master_next = master_reg;
    done_next = done_reg;
    coll_next = coll_reg;
    armed_next = armed_reg;
    busy_next = busy_reg;
    data_next = data_reg;
    count_next = count_reg;
    sout_next = sout_reg;
    sin_next = serial_in_line_i;
    sclk_in_next = sclk_now;
    if (wr_i && addr_i == SSP_OFS_CONTROL)
    begin
      enable_next = wdata_i[SSP_CTL_ENABLE_BIT];
      master_next = wdata_i[SSP_CTL_MASTER_BIT];
    end
    if (!enable_reg)
    begin
      sout_next = port_b_bit_five_i;
    end
    // status read with done set arms the clearing sequence
    if (rd_i && addr_i == SSP_OFS_STATUS)
    begin
      armed_next = done_reg;
    end
    if (data_acc)
    begin
      if (armed_reg)
      begin
        done_next = 1'b0;
        coll_next = 1'b0;
      end
      armed_next = 1'b0;
      if (wr_i)
      begin
        data_next = wdata_i;
      end
      if (busy_reg)
      begin
        coll_next = 1'b1;
      end
    end
    if (!enable_reg || (!master_reg && !master_next && 1'b0))
    begin
      busy_next = 1'b0;
      count_next = 4'h0;
    end
    else if (master_reg && !master_next)
    begin
      busy_next = 1'b0;
      count_next = 4'h0;
    end
    else
    begin
      if (rise_ev && busy_reg)
      begin
        if (lsb_first_i)
        begin
          data_next = {sin_reg, data_reg[7:1]};
        end
        else
        begin
          data_next = {data_reg[6:0], sin_reg};
        end
        count_next = count_reg + 4'h1;
        if (count_reg == SSP_BITS - 4'h1)
        begin
          done_next = 1'b1;
          busy_next = 1'b0;
        end
      end
      // next bit from the updated shifter: a fresh write or a same-cycle shift
      if (fall_ev && count_reg < SSP_BITS)
      begin
        busy_next = 1'b1;
        sout_next = out_bit(data_next, lsb_first_i);
      end
      if (count_reg == SSP_BITS && !busy_reg && !rise_ev)
      begin
        count_next = 4'h0;
      end
    end
  end

  // pin direction and read data
  always_comb
  begin
    sclk_oe_next = enable_next && master_next;
    sout_oe_next = enable_next;
    sin_used_next = enable_next;
    rdata_next = 8'h00;
    if (rd_i)
    begin
      if (addr_i == SSP_OFS_CONTROL)
      begin
        rdata_next[SSP_CTL_ENABLE_BIT] = enable_reg;
        rdata_next[SSP_CTL_MASTER_BIT] = master_reg;
      end
      else if (addr_i == SSP_OFS_STATUS)
      begin
        rdata_next[SSP_STS_DONE_BIT] = done_reg;
        rdata_next[SSP_STS_COLL_BIT] = coll_reg;
      end
      else if (addr_i == SSP_OFS_DATA)
      begin
        rdata_next = data_reg;
      end
    end
  end

  // control state registers
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      enable_reg <= 1'b0;
      master_reg <= 1'b0;
      done_reg <= 1'b0;
      coll_reg <= 1'b0;
      armed_reg <= 1'b0;
      busy_reg <= 1'b0;
      count_reg <= 4'h0;
      div_reg <= 3'h0;
      state_reg <= SSP_IDLE;
      sclk_reg <= 1'b1;
      sclk_in_reg <= 1'b1;
      sin_reg <= 1'b0;
      rdata_reg <= 8'h00;
      sclk_oe_reg <= 1'b0;
      sout_reg <= 1'b0;
      sout_oe_reg <= 1'b0;
      sin_used_reg <= 1'b0;
    end
    else
    begin
      enable_reg <= enable_next;
      master_reg <= master_next;
      done_reg <= done_next;
      coll_reg <= coll_next;
      armed_reg <= armed_next;
      busy_reg <= busy_next;
      count_reg <= count_next;
      div_reg <= div_next;
      state_reg <= state_next;
      sclk_reg <= sclk_next;
      sclk_in_reg <= sclk_in_next;
      sin_reg <= sin_next;
      rdata_reg <= rdata_next;
      sclk_oe_reg <= sclk_oe_next;
      sout_reg <= sout_next;
      sout_oe_reg <= sout_oe_next;
      sin_used_reg <= sin_used_next;
    end
  end

  // data register keeps its value through reset
  always_ff @(posedge core_clk_i)
  begin
    data_reg <= data_next;
  end

  // outputs straight from flip-flops
  assign rdata_o = rdata_reg;
  assign sclk_o = sclk_reg;
  assign sclk_oe_o = sclk_oe_reg;
  assign serial_out_line_o = sout_reg;
  assign serial_out_oe_o = sout_oe_reg;
  assign serial_in_used_o = sin_used_reg;

endmodule

// ---- ssp_top_properties.sv ----
`timescale 1ns/10ps
module ssp_chk
  import ssp_pkg::*;
(
  // watched ports
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic [1:0] rate_sel_i,
  input wire logic port_b_bit_five_i,
  input wire logic sclk_o,
  input wire logic sclk_oe_o,
  input wire logic serial_out_line_o,
  input wire logic serial_out_oe_o,
  input wire logic serial_in_used_o
);
  // one clock domain
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // reset frees the pins
  reset_idle_a: assert property (disable iff (1'b0) rst_i |=>
    sclk_o && !sclk_oe_o && !serial_out_oe_o) else $error("bad reset");
  // clock pin driven only while enabled
  clk_oe_a: assert property (sclk_oe_o |-> serial_out_oe_o)
    else $error("clock driven while disabled");
  // data pins switch together
  pin_use_a: assert property (serial_in_used_o == serial_out_oe_o)
    else $error("pin use mismatch");
  // disabled output follows port bit
  gp_out_a: assert property (!serial_out_oe_o && !$past(serial_out_oe_o) &&
    !$past(rst_i) && $stable(port_b_bit_five_i) |-> serial_out_line_o == port_b_bit_five_i)
    else $error("general output wrong");
  // read data only after a read
  rd_quiet_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("stray read data");
  // fastest rate low one cycle
  half_fast_a: assert property ($fell(sclk_o) && sclk_oe_o && rate_sel_i == SSP_DIV2 |=>
    sclk_o) else $error("div2 rate wrong");
  // slowest rate low eight cycles
  half_slow_a: assert property ($fell(sclk_o) && sclk_oe_o && rate_sel_i == SSP_DIV16 |->
    !sclk_o [*8] ##1 sclk_o) else $error("div16 rate wrong");
  // generated clock rests high when not driven
  clk_rest_a: assert property (!sclk_oe_o && !$past(sclk_oe_o) |-> sclk_o)
    else $error("clock not high");
  // data write starts master frame
  start_xfer_a: assert property (wr_i && addr_i == SSP_OFS_DATA && sclk_oe_o && sclk_o |=>
    !sclk_o) else $error("no start");
endmodule

// ---- ssp_top_tb.sv ----
`timescale 1ns/10ps
module ssp_top_tb;
  import ssp_pkg::*;
  localparam logic [7:0] EN = 8'h01 << SSP_CTL_ENABLE_BIT;
  localparam logic [7:0] MS = 8'h01 << SSP_CTL_MASTER_BIT;
  localparam logic [7:0] DN = 8'h01 << SSP_STS_DONE_BIT;
  localparam logic [7:0] CL = 8'h01 << SSP_STS_COLL_BIT;
  logic core_clk_i, rst_i, wr_i, rd_i, lsb_first_i, port_b_bit_five_i, go, rd_q;
  logic [7:0] addr_i, wdata_i, rdata_o, ptx, prx, last;
  logic [1:0] rate_sel_i;
  wire sclk_o, sclk_oe_o, serial_out_line, sdo_oe, in_used, pdrv, serial_in_line;
  wire sclk_w = sclk_oe_o ? sclk_o : pdrv;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [7:0] exp_q[$];
  ssp_top DUT (.core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rate_sel_i(rate_sel_i),
    .lsb_first_i(lsb_first_i), .port_b_bit_five_i(port_b_bit_five_i),
    .serial_in_line_i(serial_in_line), .sclk_i(sclk_w), .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o),
    .serial_out_line_o(serial_out_line), .serial_out_oe_o(sdo_oe), .serial_in_used_o(in_used));
  ssp_peer u_peer (.core_clk_i(core_clk_i), .sclk_w_i(sclk_w), .sdo_w_i(serial_out_line), .go_i(go),
    .tx_i(ptx), .sclk_drv_o(pdrv), .sdi_o(serial_in_line), .rx_o(prx));
  // clock
  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    rd_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    addr_i <= a;
    rd_i <= 1'b1;
    wr_i <= 1'b0;
    exp_q.push_back(e);
    @(posedge core_clk_i);
  endtask
  task automatic idle(input int n);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    repeat (n) @(posedge core_clk_i);
  endtask
  function automatic logic [7:0] rv(input logic [7:0] b, input logic l);
    rv = l ? {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]} : b;
  endfunction
  // one byte each way; c adds a mid-frame access
  task automatic xfer(input bit m, input bit c);
    logic [7:0] d;
    d = 8'($urandom);
    ptx <= 8'($urandom);
    wr(SSP_OFS_DATA, d);
    go <= !m;
    idle(6);
    go <= 1'b0;
    if (c)
      wr(SSP_OFS_DATA, d);
    idle(m ? (16 << rate_sel_i) + 12 : 80);
    rd(SSP_OFS_STATUS, c ? DN | CL : DN);
    if (c)
      wr(SSP_OFS_DATA, d);
    else
      rd(SSP_OFS_DATA, rv(ptx, lsb_first_i));
    rd(SSP_OFS_STATUS, 8'h00);
    idle(1);
    if (!c)
      chk(prx, rv(d, lsb_first_i));
    last = rv(ptx, lsb_first_i);
  endtask
  // read answers against notes, and hang guard
  always @(posedge core_clk_i)
  begin
    rd_q <= rd_i;
    if (rd_q === 1'b1)
      chk(rdata_o, exp_q.pop_front());
    cyc++;
    if (cyc == 6000)
    begin
      err_count++;
      close_out();
    end
  end
  // main sequence
  initial
  begin
    rst_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    go = 1'b0;
    rate_sel_i = 2'h0;
    lsb_first_i = 1'b0;
    port_b_bit_five_i = 1'b0;
    ptx = 8'h00;
    void'($urandom(90410));
    repeat (6) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(SSP_OFS_STATUS, 8'h00);
    rd(SSP_OFS_CONTROL, 8'h00);
    rd(8'h00, 8'h00);
    wr(SSP_OFS_CONTROL, MS);
    rd(SSP_OFS_CONTROL, MS);
    wr(SSP_OFS_CONTROL, EN);
    xfer(1'b0, 1'b1);
    xfer(1'b0, 1'b0);
    wr(SSP_OFS_CONTROL, EN | MS);
    for (int i = 0; i < 8; i++)
    begin
      rate_sel_i <= 2'(i >> 1);
      lsb_first_i <= i[0];
      port_b_bit_five_i <= 1'($urandom);
      xfer(1'b1, 1'b0);
    end
    rst_i <= 1'b1;
    idle(6);
    rst_i <= 1'b0;
    rd(SSP_OFS_DATA, last);
    rate_sel_i <= SSP_DIV4;
    // abort by dropping master, then enable
    for (int j = 0; j < 2; j++)
    begin
      wr(SSP_OFS_CONTROL, EN | MS);
      wr(SSP_OFS_DATA, 8'hA5);
      idle(10);
      wr(SSP_OFS_CONTROL, j == 0 ? EN : MS);
      idle(40);
      rd(SSP_OFS_STATUS, 8'h00);
    end
    idle(2);
    close_out();
  end
endmodule
bind ssp_top ssp_chk u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rate_sel_i(rate_sel_i),
  .port_b_bit_five_i(port_b_bit_five_i), .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o),
  .serial_out_line_o(serial_out_line_o), .serial_out_oe_o(serial_out_oe_o),
  .serial_in_used_o(serial_in_used_o));
